// ===== src/pers_cfg.svh
// Constants shared by both ends of the program/erase resume link.
`ifndef PERS_CFG_SVH
`define PERS_CFG_SVH
// What this block does
// - Resume is one opcode; later bytes ignored.
// - Resume starts at select release, within latency.
// - Resume clears the matching suspend flag.
// - Busy shows while the resumed operation runs.
// - Both suspended: program resumes, erase stays.
// - Host resumes again afterwards for the erase.
// - Suspend ignored while a resume still settles.
// - Host waits latency or polls before suspending.
// - No deep power-down wake while suspended.
// - No ultra-deep power-down entry while suspended.
// - Status and ID reads always answered.
// - Hardware and software reset always honoured.
// - No deep power-down entry while suspended.
// ****************************************************
// Opcodes
// ****************************************************
`define PERS_OP_RESUME   8'hD0
`define PERS_OP_SUSPEND  8'hB0
`define PERS_OP_STATUS   8'hD7
`define PERS_OP_ID       8'h9F
`define PERS_OP_SWRST    8'hF0
`define PERS_OP_DPD      8'hB9
`define PERS_OP_DPD_WAKE 8'hAB
`define PERS_OP_UDPD     8'h79
// ****************************************************
// Status byte fields and identity
// ****************************************************
`define PERS_ST_READY 7
`define PERS_ST_ES    2
`define PERS_ST_PS2   1
`define PERS_ST_PS1   0
// Identity byte; the value is arbitrary.
`define PERS_ID_BYTE  8'h5A
// ****************************************************
// Timing
// ****************************************************
`define PERS_CLK_NS     100
`define PERS_RES_NS     2000
`define PERS_RES_CYC    (`PERS_RES_NS / `PERS_CLK_NS)
`define PERS_PROG_CYC   16'h0190
`define PERS_ERASE_CYC  16'h07D0
`define PERS_SCLK_HALF  4'h8
// ****************************************************
// Host register offsets (byte addresses)
// ****************************************************
`define PERS_REG_CMD    8'h00
`define PERS_REG_STAT   8'h04
`define PERS_REG_IRQ    8'h08
`define PERS_REG_MASK   8'h0C
`endif

// ===== src/pers_pkg.sv
// Types shared by both ends of the resume link.
package pers_pkg;
  // Life of one program or erase operation.
  typedef enum logic [1:0] {PERS_IDLE, PERS_RUN, PERS_SUSP} pers_op_type;
  // Phases of one host frame.
  typedef enum logic [1:0] {PERS_H_IDLE, PERS_H_SHIFT, PERS_H_END} pers_hst_type;
endpackage : pers_pkg

// ===== src/pers_spi_if.sv
// Serial link between the host controller and the flash device.
`timescale 1ns/10ps
`default_nettype none
interface pers_spi_if;
  logic sclk;   // Serial clock, made by the host.
  logic cs_n;   // Select, active low.
  logic mosi;   // Host to device data.
  logic miso;   // Device to host data.
  modport dev  (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : pers_spi_if
`default_nettype wire

// ===== src/pers_sync.sv
// Two-stage synchroniser with edge pulses for foreign inputs.
`timescale 1ns/10ps
`default_nettype none
module pers_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Foreign levels in.
  input  wire logic [W-1:0] d_i,
  // Synchronised level and edges out.
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  logic [W-1:0] meta_q;  // First stage, read only by the second.
  logic [W-1:0] sync_q;  // Second stage, safe to use.
  logic [W-1:0] prev_q;  // Delayed copy for edge finding.

  // The first stage feeds the second and nothing else.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign q_o    = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;
endmodule : pers_sync
`default_nettype wire

// ===== src/pers_device.sv
// Flash device end: decodes resume, suspend, reads and reset on the link.
`timescale 1ns/10ps
`default_nettype none
`include "pers_cfg.svh"
module pers_device
  import pers_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Link to the host.
  pers_spi_if.dev         spi,
  // Hardware reset pin, active low, asynchronous to clk_i.
  input  wire logic       hw_rst_n_i,
  // Operation start from the array core: 0 prog buf1, 1 prog buf2, 2 erase.
  input  wire logic       op_start_i,
  input  wire logic [1:0] op_kind_i,
  // Visible state.
  output logic            busy_o,
  output logic            resuming_o,
  output logic [2:0]      susp_o
);
  // ****************************************************
  // Input synchronisation
  // ****************************************************
  logic [3:0] pin_q;   // Synchronised sclk, cs_n, mosi, reset pin.
  logic [3:0] pin_r;   // Rising edges.
  logic [3:0] pin_f;   // Falling edges.

  pers_sync #(.W(4)) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .d_i    ({hw_rst_n_i, spi.mosi, spi.cs_n, spi.sclk}),
    .q_o    (pin_q),
    .rise_o (pin_r),
    .fall_o (pin_f)
  );

  logic sel_start;   // Select just went low.
  logic sel_end;     // Select just went high.
  logic clk_rise;    // Serial clock rose inside a frame.
  logic clk_fall;    // Serial clock fell inside a frame.
  logic hw_rst;      // Hardware reset pin held low.

  assign sel_start = pin_f[1];
  assign sel_end   = pin_r[1];
  assign clk_rise  = pin_r[0] & ~pin_q[1];
  assign clk_fall  = pin_f[0] & ~pin_q[1];
  assign hw_rst    = ~pin_q[3];

  // ****************************************************
  // Operation state declarations
  // ****************************************************
  pers_op_type prog_q, prog_d;     // Program operation.
  pers_op_type erase_q, erase_d;   // Erase operation.
  logic        buf2_q, buf2_d;     // Program comes from buffer two.
  logic [15:0] pleft_q, pleft_d;   // Program work still to do.
  logic [15:0] eleft_q, eleft_d;   // Erase work still to do.
  logic [7:0]  res_q, res_d;       // Resume latency still to run.
  logic        busy_q, busy_d;     // Registered busy output.
  logic [2:0]  susp_q, susp_d;     // Registered suspend flags.
  logic        resm_q, resm_d;     // Registered resuming output.
  logic [7:0]  stat_byte;          // Status byte sent to the host.

  // Status byte: ready high when idle, suspend flags in the low bits.
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[`PERS_ST_READY] = ~busy_q;
    stat_byte[`PERS_ST_PS1]   = susp_q[0];
    stat_byte[`PERS_ST_PS2]   = susp_q[1];
    stat_byte[`PERS_ST_ES]    = susp_q[2];
  end

  // ****************************************************
  // Link byte decoder
  // ****************************************************
  logic [3:0] bits_q, bits_d;   // Bits of the opcode seen so far.
  logic [7:0] shin_q, shin_d;   // Incoming shift register.
  logic [7:0] opc_q, opc_d;     // Opcode of this frame.
  logic       opv_q, opv_d;     // Opcode complete.
  logic [7:0] shout_q, shout_d; // Outgoing shift register.
  logic       miso_q, miso_d;   // Data to host.

  // Only the first byte is decoded; later bytes are never looked at.
  always_comb begin
    bits_d  = bits_q;
    shin_d  = shin_q;
    opc_d   = opc_q;
    opv_d   = opv_q;
    shout_d = shout_q;
    miso_d  = miso_q;
    if (sel_start) begin
      bits_d = 4'h0;
      opv_d  = 1'b0;
      miso_d = 1'b0;
    end else if (sel_end) begin
      miso_d = 1'b0;
    end else if (clk_rise && !opv_q) begin
      shin_d = {shin_q[6:0], pin_q[2]};
      bits_d = bits_q + 4'h1;
      if (bits_q == 4'h7) begin
        opc_d = {shin_q[6:0], pin_q[2]};
        opv_d = 1'b1;
        // Reads are answered in every state, suspended or not.
        if ({shin_q[6:0], pin_q[2]} == `PERS_OP_STATUS) begin
          shout_d = stat_byte;
        end else if ({shin_q[6:0], pin_q[2]} == `PERS_OP_ID) begin
          shout_d = `PERS_ID_BYTE;
        end else begin
          shout_d = 8'h00;
        end
      end
    end else if (clk_fall && opv_q) begin
      // The answer repeats for as long as the host keeps clocking.
      miso_d  = shout_q[7];
      shout_d = {shout_q[6:0], shout_q[7]};
    end
  end

  // Link registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bits_q  <= 4'h0;
      shin_q  <= 8'h00;
      opc_q   <= 8'h00;
      opv_q   <= 1'b0;
      shout_q <= 8'h00;
      miso_q  <= 1'b0;
    end else begin
      bits_q  <= bits_d;
      shin_q  <= shin_d;
      opc_q   <= opc_d;
      opv_q   <= opv_d;
      shout_q <= shout_d;
      miso_q  <= miso_d;
    end
  end

  assign spi.miso = miso_q;

  // ****************************************************
  // Operation sequencer
  // ****************************************************
  logic cmd_end;   // A complete opcode ended with select release.
  assign cmd_end = sel_end && opv_q;

  // Commands act at select release; work counts only after the latency.
  always_comb begin
    prog_d  = prog_q;
    erase_d = erase_q;
    buf2_d  = buf2_q;
    pleft_d = pleft_q;
    eleft_d = eleft_q;
    res_d   = res_q;
    if (res_q != 8'h00) begin
      res_d = res_q - 8'h01;
    end else if (prog_q == PERS_RUN) begin
      pleft_d = pleft_q - 16'h0001;
      if (pleft_q == 16'h0001) begin
        prog_d = PERS_IDLE;
      end
    end else if (erase_q == PERS_RUN) begin
      eleft_d = eleft_q - 16'h0001;
      if (eleft_q == 16'h0001) begin
        erase_d = PERS_IDLE;
      end
    end
    if (op_start_i && prog_q != PERS_RUN && erase_q != PERS_RUN) begin
      // A program may start while an erase sits suspended.
      if (op_kind_i[1] == 1'b0 && prog_q == PERS_IDLE) begin
        prog_d  = PERS_RUN;
        buf2_d  = op_kind_i[0];
        pleft_d = `PERS_PROG_CYC;
      end else if (op_kind_i == 2'h2 && prog_q == PERS_IDLE && erase_q == PERS_IDLE) begin
        erase_d = PERS_RUN;
        eleft_d = `PERS_ERASE_CYC;
      end
    end
    if (cmd_end && opc_q == `PERS_OP_RESUME) begin
      // Program first; a lone resume with nothing suspended is a no-op.
      if (prog_q == PERS_SUSP) begin
        prog_d = PERS_RUN;
        res_d  = 8'(`PERS_RES_CYC);
      end else if (erase_q == PERS_SUSP && prog_q == PERS_IDLE) begin
        erase_d = PERS_RUN;
        res_d   = 8'(`PERS_RES_CYC);
      end
    end
    if (cmd_end && opc_q == `PERS_OP_SUSPEND && res_q == 8'h00) begin
      if (prog_q == PERS_RUN) begin
        prog_d = PERS_SUSP;
      end else if (erase_q == PERS_RUN) begin
        erase_d = PERS_SUSP;
      end
    end
    if (hw_rst || (cmd_end && opc_q == `PERS_OP_SWRST)) begin
      prog_d  = PERS_IDLE;
      erase_d = PERS_IDLE;
      res_d   = 8'h00;
    end
    busy_d    = prog_d == PERS_RUN || erase_d == PERS_RUN;
    resm_d    = res_d != 8'h00;
    susp_d[0] = prog_d == PERS_SUSP && !buf2_d;
    susp_d[1] = prog_d == PERS_SUSP && buf2_d;
    susp_d[2] = erase_d == PERS_SUSP;
  end

  // Operation registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_q  <= PERS_IDLE;
      erase_q <= PERS_IDLE;
      buf2_q  <= 1'b0;
      pleft_q <= 16'h0000;
      eleft_q <= 16'h0000;
      res_q   <= 8'h00;
      busy_q  <= 1'b0;
      resm_q  <= 1'b0;
      susp_q  <= 3'h0;
    end else begin
      prog_q  <= prog_d;
      erase_q <= erase_d;
      buf2_q  <= buf2_d;
      pleft_q <= pleft_d;
      eleft_q <= eleft_d;
      res_q   <= res_d;
      busy_q  <= busy_d;
      resm_q  <= resm_d;
      susp_q  <= susp_d;
    end
  end

  assign busy_o     = busy_q;
  assign resuming_o = resm_q;
  assign susp_o     = susp_q;
endmodule : pers_device
`default_nettype wire

// ===== src/pers_host.sv
// Host end: Wishbone-controlled frame engine that guards forbidden opcodes.
`timescale 1ns/10ps
`default_nettype none
`include "pers_cfg.svh"
module pers_host
  import pers_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt.
  output logic             irq_o,
  // Link to the device.
  pers_spi_if.host         spi
);
  // ****************************************************
  // State declarations
  // ****************************************************
  pers_hst_type st_q, st_d;        // Frame phase.
  logic [3:0]  div_q, div_d;       // Half-period divider.
  logic [4:0]  cnt_q, cnt_d;       // Bits sent.
  logic [4:0]  nb_q, nb_d;         // Bits in this frame.
  logic [15:0] tx_q, tx_d;         // Outgoing bits.
  logic [7:0]  rx_q, rx_d;         // Last byte received.
  logic [7:0]  opc_q, opc_d;       // Opcode of the last frame.
  logic        sclk_q, sclk_d;     // Serial clock out.
  logic        cs_q, cs_d;         // Select out, active low.
  logic        mosi_q, mosi_d;     // Data out.
  logic        susp_q, susp_d;     // Device believed suspended.
  logic [7:0]  hold_q, hold_d;     // Resume latency still to wait.
  logic [1:0]  ists_q, ists_d;     // Sticky events: done, refused.
  logic [1:0]  mask_q, mask_d;     // Interrupt enables.
  logic        ack_q, ack_d;       // Bus acknowledge.
  logic [31:0] dat_q, dat_d;       // Bus read data.
  logic        irq_q, irq_d;       // Interrupt level.
  logic        miso_s;             // Synchronised device data.

  pers_sync #(.W(1)) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .d_i    (spi.miso),
    .q_o    (miso_s),
    .rise_o (),
    .fall_o ()
  );

  // Opcodes that must never reach a suspended device.
  function automatic logic pers_forbidden(input logic [7:0] op);
    pers_forbidden = op == `PERS_OP_DPD || op == `PERS_OP_DPD_WAKE || op == `PERS_OP_UDPD;
  endfunction : pers_forbidden

  // ****************************************************
  // Bus, guard and frame engine
  // ****************************************************
  logic wr;     // A write is taken this cycle.
  logic rd;     // A read is taken this cycle.
  logic tick;   // Half-period enable.
  logic stop;   // The requested opcode is refused.
  logic done;   // Frame finished this cycle.

  // Suspend state is only as fresh as the last status read, so stay pessimistic.
  always_comb begin
    st_d = st_q;
    div_d = div_q;
    cnt_d = cnt_q;
    nb_d = nb_q;
    tx_d = tx_q;
    rx_d = rx_q;
    opc_d = opc_q;
    sclk_d = sclk_q;
    cs_d = cs_q;
    mosi_d = mosi_q;
    susp_d = susp_q;
    hold_d = hold_q;
    mask_d = mask_q;
    dat_d = dat_q;
    wr   = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i && wb_sel_i[0];
    rd   = wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i;
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    tick = st_q != PERS_H_IDLE && div_q == `PERS_SCLK_HALF - 4'h1;
    div_d = (st_q == PERS_H_IDLE || tick) ? 4'h0 : div_q + 4'h1;
    done = 1'b0;
    stop = (susp_q && pers_forbidden(wb_dat_i[7:0]))
        || (hold_q != 8'h00 && wb_dat_i[7:0] == `PERS_OP_SUSPEND)
        || st_q != PERS_H_IDLE;
    if (hold_q != 8'h00) begin
      hold_d = hold_q - 8'h01;
    end
    if (wr && wb_adr_i == `PERS_REG_CMD && !stop) begin
      st_d   = PERS_H_SHIFT;
      opc_d  = wb_dat_i[7:0];
      tx_d   = {wb_dat_i[7:0], 8'h00};
      mosi_d = wb_dat_i[7];
      cs_d   = 1'b0;
      cnt_d  = 5'h00;
      nb_d   = (wb_dat_i[7:0] == `PERS_OP_STATUS || wb_dat_i[7:0] == `PERS_OP_ID) ? 5'h10 : 5'h08;
    end
    unique case (st_q)
      PERS_H_IDLE: begin
      end
      PERS_H_SHIFT: begin
        if (tick && !sclk_q) begin
          sclk_d = 1'b1;
          rx_d   = {rx_q[6:0], miso_s};
        end else if (tick) begin
          sclk_d = 1'b0;
          if (cnt_q == nb_q - 5'h01) begin
            st_d = PERS_H_END;
          end else begin
            cnt_d  = cnt_q + 5'h01;
            tx_d   = {tx_q[14:0], 1'b0};
            mosi_d = tx_q[14];
          end
        end
      end
      PERS_H_END: begin
        if (tick && !cs_q) begin
          cs_d = 1'b1;
        end else if (tick) begin
          st_d = PERS_H_IDLE;
          done = 1'b1;
        end
      end
    endcase
    if (done && opc_q == `PERS_OP_RESUME) begin
      hold_d = 8'(`PERS_RES_CYC);
    end
    if (done && opc_q == `PERS_OP_SUSPEND) begin
      susp_d = 1'b1;
    end
    if (done && opc_q == `PERS_OP_STATUS) begin
      susp_d = rx_q[`PERS_ST_PS1] | rx_q[`PERS_ST_PS2] | rx_q[`PERS_ST_ES];
    end
    if (wr && wb_adr_i == `PERS_REG_MASK) begin
      mask_d = wb_dat_i[1:0];
    end
    // Write one clears, but a new event in the same cycle wins.
    ists_d = ists_q;
    if (wr && wb_adr_i == `PERS_REG_IRQ) begin
      ists_d = ists_q & ~wb_dat_i[1:0];
    end
    ists_d = ists_d | {wr && wb_adr_i == `PERS_REG_CMD && stop, done};
    irq_d  = (ists_d & mask_d) != 2'h0;
    if (rd) begin
      unique case (wb_adr_i)
        `PERS_REG_CMD:  dat_d = {24'h000000, opc_q};
        `PERS_REG_STAT: dat_d = {16'h0000, rx_q, 5'h00, hold_q != 8'h00, susp_q, st_q != PERS_H_IDLE};
        `PERS_REG_IRQ:  dat_d = {30'h00000000, ists_q};
        `PERS_REG_MASK: dat_d = {30'h00000000, mask_q};
        default:        dat_d = 32'h00000000;
      endcase
    end
  end

  // Registers of the host end.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= PERS_H_IDLE;
      div_q <= 4'h0;
      cnt_q <= 5'h00;
      nb_q <= 5'h08;
      tx_q <= 16'h0000;
      rx_q <= 8'h00;
      opc_q <= 8'h00;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      mosi_q <= 1'b0;
      susp_q <= 1'b0;
      hold_q <= 8'h00;
      ists_q <= 2'h0;
      mask_q <= 2'h0;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      cnt_q <= cnt_d;
      nb_q <= nb_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      opc_q <= opc_d;
      sclk_q <= sclk_d;
      cs_q <= cs_d;
      mosi_q <= mosi_d;
      susp_q <= susp_d;
      hold_q <= hold_d;
      ists_q <= ists_d;
      mask_q <= mask_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      irq_q <= irq_d;
    end
  end

  assign spi.sclk = sclk_q;
  assign spi.cs_n = cs_q;
  assign spi.mosi = mosi_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_o    = irq_q;
endmodule : pers_host
`default_nettype wire

// ===== bench/pers_props.sv
// Checker: timing relations on the link and the device resume state.
`timescale 1ns/10ps
`default_nettype none
`include "pers_cfg.svh"
module pers_props (
  // Clock and resets.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       hw_rst_n_i,
  // Link wires.
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  input  wire logic       miso,
  // Device state.
  input  wire logic       busy_o,
  input  wire logic       resuming_o,
  input  wire logic [2:0] susp_o
);
  localparam int RES_CYC = `PERS_RES_CYC;  // Resume latency in clocks.
  logic [7:0] res_cnt_q;  // Cycles spent resuming so far.
  logic [7:0] res_cnt_d;  // Next count.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Count the resume latency; a plain repetition would be too long.
  always_comb begin
    res_cnt_d = resuming_o ? res_cnt_q + 8'h01 : 8'h00;
  end
  // Register the count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_cnt_q <= 8'h00;
    end else begin
      res_cnt_q <= res_cnt_d;
    end
  end
  // A resume takes effect with busy showing.
  sequence s_res_start;
    $rose(resuming_o) ##0 busy_o;
  endsequence
  // The select rose a few clocks ago.
  sequence s_frame_end;
    $past(cs_n, 2) && !$past(cs_n, 6);
  endsequence
  a_sclk_idle_low: assert property (cs_n |-> !sclk) else $error("serial clock not idle low");
  a_miso_rests: assert property (cs_n [*6] |-> !miso) else $error("device data not released");
  a_resume_clears: assert property (s_res_start |-> $countones($past(susp_o)) == $countones(susp_o) + 1
    && (susp_o & ~$past(susp_o)) == 3'h0) else $error("resume did not clear one flag");
  a_prog_first: assert property (s_res_start ##0 ($past(susp_o[2]) && $past(susp_o[1:0]) != 2'h0)
    |-> susp_o[2]) else $error("erase resumed before program");
  a_busy_covers: assert property (resuming_o |-> busy_o) else $error("not busy while resuming");
  a_latency_len: assert property ($fell(resuming_o) && hw_rst_n_i |-> res_cnt_q == RES_CYC)
    else $error("resume latency length wrong");
  a_suspend_ignored: assert property (resuming_o |=> (susp_o & ~$past(susp_o)) == 3'h0)
    else $error("suspend taken while resuming");
  a_act_window: assert property (s_res_start |-> s_frame_end) else $error("resume not after select release");
  a_idle_no_resume: assert property (!busy_o && susp_o == 3'h0 |=> !resuming_o)
    else $error("resume with nothing suspended");
endmodule : pers_props
`default_nettype wire

// ===== bench/pers_tb.sv
// Testbench: host and device joined by the link, checked against a model.
`timescale 1ns/10ps
`default_nettype none
`include "pers_cfg.svh"
module pers_tb;
  // *****
  // Stimulus, observation and model state
  // *****
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        wb_cyc = 1'h0;
  logic        wb_stb = 1'h0;
  logic        wb_we = 1'h0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic        wb_ack, irq, busy, resuming;
  logic        hw_rst_n = 1'h1;
  logic        op_start = 1'h0;
  logic [1:0]  op_kind = 2'h0;
  logic [2:0]  susp;
  logic [2:0]  m_susp;  // Model suspend flags.
  logic        m_busy;  // Model busy.
  int          m_run;   // Model running kind, -1 for none.
  int          errors, check_count, k;
  logic [31:0] rd;
  pers_spi_if i_pers_spi_if ();
  pers_host i_pers_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .irq_o(irq), .spi(i_pers_spi_if));
  pers_device i_pers_device (.clk_i(clk_i), .rst_i(rst_i), .spi(i_pers_spi_if), .hw_rst_n_i(hw_rst_n),
    .op_start_i(op_start), .op_kind_i(op_kind), .busy_o(busy), .resuming_o(resuming), .susp_o(susp));
  pers_props i_pers_props (.clk_i(clk_i), .rst_i(rst_i), .hw_rst_n_i(hw_rst_n), .sclk(i_pers_spi_if.sclk),
    .cs_n(i_pers_spi_if.cs_n), .mosi(i_pers_spi_if.mosi), .miso(i_pers_spi_if.miso), .busy_o(busy),
    .resuming_o(resuming), .susp_o(susp));
  // Free-running clock at 10 MHz.
  always #50 clk_i = ~clk_i;
  // *****
  // Checks, bus cycles and model
  // *****
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // Compare a register or link value.
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  // Compare the device state with the model.
  task automatic chk_dev();
    check_count++;
    if ({busy, susp} !== {m_busy, m_susp}) begin
      errors++;
      $display("unexpected state at %0t: got %h expected %h", $time, {busy, susp}, {m_busy, m_susp});
    end
  endtask : chk_dev
  // One classic cycle; the request holds until ack is sampled.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= dat;
    wb_sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'h1 && n < 50);
    if (wb_ack !== 1'h1) errors++;
    q = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_we <= 1'h0;
  endtask : wb
  // Model reaction to a completed command.
  task automatic m_act(input logic [7:0] op);
    if (op == `PERS_OP_SUSPEND && m_run >= 0) begin
      m_susp[m_run] = 1'h1;
      m_run = -1;
      m_busy = 1'h0;
    end else if (op == `PERS_OP_RESUME && m_susp != 3'h0) begin
      m_run = m_susp[0] ? 0 : (m_susp[1] ? 1 : 2);
      m_susp[m_run] = 1'h0;
      m_busy = 1'h1;
    end else if (op == `PERS_OP_SWRST) begin
      m_susp = 3'h0;
      m_run = -1;
      m_busy = 1'h0;
    end
  endtask : m_act
  // Send one opcode, let the device act, optionally wait for the frame to end.
  task automatic send(input logic [7:0] op, input logic idle, output logic [31:0] st);
    int n;
    n = 0;
    wb(1'h1, `PERS_REG_CMD, {24'h0, op}, st);
    while (i_pers_spi_if.cs_n !== 1'h1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400) errors++;
    repeat (6) @(posedge clk_i);
    m_act(op);
    st = 32'h1;
    while (idle && st[0] !== 1'h0 && n < 900) begin
      wb(1'h0, `PERS_REG_STAT, 32'h0, st);
      n++;
    end
    if (idle && st[0] !== 1'h0) errors++;
  endtask : send
  // A command the host must turn away: refused flag, interrupt, no change.
  task automatic refuse(input logic [7:0] op);
    wb(1'h1, `PERS_REG_CMD, {24'h0, op}, rd);
    wb(1'h0, `PERS_REG_IRQ, 32'h0, rd);
    chk_reg(rd & 32'h2, 32'h2);
    chk_reg({31'h0, irq}, 32'h1);
    wb(1'h1, `PERS_REG_IRQ, 32'h3, rd);
    chk_dev();
  endtask : refuse
  // Start an operation from the core and let it run a random while.
  task automatic start(input logic [1:0] kind);
    @(posedge clk_i);
    op_start <= 1'h1;
    op_kind <= kind;
    @(posedge clk_i);
    op_start <= 1'h0;
    m_run = kind;
    m_busy = 1'h1;
    repeat (20 + $urandom % 60) @(posedge clk_i);
  endtask : start
  // Let the running operation finish.
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'h0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    m_busy = 1'h0;
    m_run = -1;
    if (busy !== 1'h0) errors++;
  endtask : wait_idle
  // *****
  // Scenarios
  // *****
  initial begin
    errors = 0;
    check_count = 0;
    m_susp = 3'h0;
    m_busy = 1'h0;
    m_run = -1;
    k = $urandom(32'h6055);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    // Registers clear after reset; 0x10 is unmapped and ignores writes.
    wb(1'h1, 8'h10, 32'hFF, rd);
    for (int i = 0; i < 5; i++) begin
      wb(1'h0, 8'(4 * i), 32'h0, rd);
      chk_reg(rd, 32'h0);
    end
    wb(1'h1, `PERS_REG_MASK, 32'h3, rd);
    send(`PERS_OP_RESUME, 1'h1, rd);
    chk_dev();
    k = $urandom % 2;
    start(2'(k));
    send(`PERS_OP_SUSPEND, 1'h1, rd);
    chk_dev();
    send(`PERS_OP_STATUS, 1'h1, rd);
    chk_reg({24'h0, rd[15:8] & 8'h87}, {24'h0, ~m_busy, 4'h0, m_susp});
    send(`PERS_OP_ID, 1'h1, rd);
    chk_reg({24'h0, rd[15:8]}, {24'h0, `PERS_ID_BYTE});
    refuse(`PERS_OP_DPD);
    refuse(`PERS_OP_DPD_WAKE);
    refuse(`PERS_OP_UDPD);
    send(`PERS_OP_RESUME, 1'h0, rd);
    chk_dev();
    refuse(`PERS_OP_SUSPEND);
    wait_idle();
    chk_dev();
    // Both suspended: the program goes first, the erase needs a second resume.
    start(2'h2);
    send(`PERS_OP_SUSPEND, 1'h1, rd);
    start(2'(1 - k));
    send(`PERS_OP_SUSPEND, 1'h1, rd);
    chk_dev();
    send(`PERS_OP_RESUME, 1'h1, rd);
    chk_dev();
    wait_idle();
    send(`PERS_OP_RESUME, 1'h1, rd);
    chk_dev();
    wait_idle();
    // Software and pin resets while suspended.
    start(2'h0);
    send(`PERS_OP_SUSPEND, 1'h1, rd);
    send(`PERS_OP_SWRST, 1'h1, rd);
    chk_dev();
    start(2'h1);
    send(`PERS_OP_SUSPEND, 1'h1, rd);
    hw_rst_n <= 1'h0;
    repeat (5) @(posedge clk_i);
    hw_rst_n <= 1'h1;
    repeat (3) @(posedge clk_i);
    m_act(`PERS_OP_SWRST);
    chk_dev();
    // Interrupt masking and clearing.
    wb(1'h1, `PERS_REG_MASK, 32'h0, rd);
    send(`PERS_OP_STATUS, 1'h1, rd);
    chk_reg({31'h0, irq}, 32'h0);
    wb(1'h1, `PERS_REG_MASK, 32'h1, rd);
    wb(1'h0, `PERS_REG_IRQ, 32'h0, rd);
    chk_reg({31'h0, irq}, 32'h1);
    wb(1'h1, `PERS_REG_IRQ, 32'h1, rd);
    wb(1'h0, `PERS_REG_IRQ, 32'h0, rd);
    chk_reg({31'h0, irq}, 32'h0);
    end_sim();
  end
  // Watchdog: the run needs some 5000 clocks.
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    end_sim();
  end
endmodule : pers_tb
`default_nettype wire
